// >>> core/ext_bus_pkg.sv
// constants and carrier types for the external bus pin multiplexer
package ext_bus_pkg;

	// ------------------------------------------------------------
	// port geometry
	// ------------------------------------------------------------
	localparam int NPORT = 9;
	localparam int PW = 8;
	localparam int P_ZERO = 0;
	localparam int P_ONE = 1;
	localparam int P_TWO = 2;
	localparam int P_THREE = 3;
	localparam int P_FOUR = 4;
	localparam int P_FIVE = 5;
	localparam int P_SIX = 6;
	localparam int P_SEVEN = 7;
	localparam int P_EIGHT = 8;

	typedef logic [PW-1:0] port_t;
	typedef logic [NPORT-1:0][PW-1:0] port_set_t;

	// ------------------------------------------------------------
	// register map, byte offsets on the register port
	// ------------------------------------------------------------
	localparam logic [7:0] DATA_OFS [NPORT] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h12};
	localparam logic [7:0] DIR_OFS [NPORT] = '{8'h04, 8'h05, 8'h08, 8'h09, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h13};
	localparam logic [7:0] CFG_OFS = 8'h14;
	localparam int CFG_MEMEXP_BIT = 0;
	localparam int CFG_PHASE_IO_BIT = 1;
	localparam int CFG_MICRO_BIT = 2;
	localparam port_t RESET_VAL = 8'h00;

	// implemented pins and alternate-function reach per port
	localparam port_t PIN_MASK [NPORT] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	localparam port_t ALT_SEL_MASK [NPORT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	localparam port_t ALT_OUT_MASK [NPORT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF};

	// port four bit roles under external bus operation
	localparam int HOLD_BIT = 0;
	localparam int READY_BIT = 1;
	localparam int PHASE_BIT = 2;

	// control pin synchroniser slots
	localparam int CS_STRAP = 0;
	localparam int CS_BYTE = 1;
	localparam int CS_RST_N = 2;
	localparam int NCS = 3;

	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_MEMEXP = 2'b01,
		MODE_MICRO = 2'b11
	} proc_mode_e;

	// request from the internal bus interface unit
	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] wdata;
		logic strobe_n;
		logic write;
		logic bhe_n;
		logic ale;
		logic hold_acknowledge;
		logic phase;
	} bus_req_s;

	// one port's worth of peripheral alternate function
	typedef struct packed {
		port_t sel;
		port_t oe;
		port_t out;
	} alt_s;

	// one port's worth of pad drive
	typedef struct packed {
		port_t out;
		port_t oe_n;
	} pin_s;

endpackage

// >>> core/external_bus_pin_mux.sv
// pin multiplexer: general ports, external bus functions and peripheral alternates
// Operation
// R1: strap low single/expansion, high microprocessor
// R2: held in reset while reset pin low
// R3: external transfers only while enable strobe low
// R4: width pin low 16-bit, high 8-bit
// R5: partner keeps width pin fixed
// R6: per-pin direction register in single-chip
// R7: reset clears direction, all pins input
// R8: port zero carries address low byte
// R9: wide bus: port one data/address by strobe
// R10: narrow bus: port one address only
// R11: port two data low/address high by strobe
// R12: port three outputs bus control signals
// R13: port four: hold, ready in, phase out
// R14: expansion mode may free phase clock pin
// R15: port five timer, motor, key functions
// R16: port six timer, interrupt, motor functions
// R17: port seven analog converter inputs
// R18: port eight serial, analog out, interrupts
// R19: bus or peripheral function owns pin
//
// Local design decisions: strobed register access and the address map.
module external_bus_pin_mux (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic reset_pin_n,
	input wire logic processor_mode_strap,
	input wire logic bus_width_pin,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire ext_bus_pkg::bus_req_s bus_req,
	output logic [15:0] bus_rdata,
	output logic hold_request,
	output logic ready_pin_n,
	output logic enable_strobe_n,
	output logic core_reset,
	input wire ext_bus_pkg::alt_s [ext_bus_pkg::NPORT-1:0] alt_fn,
	output ext_bus_pkg::port_set_t pin_level,
	input wire ext_bus_pkg::port_set_t pad_in,
	output ext_bus_pkg::pin_s [ext_bus_pkg::NPORT-1:0] pad
);

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	ext_bus_pkg::port_set_t pad_meta_q, pad_sync_q;
	logic [ext_bus_pkg::NCS-1:0] ctl_meta_q, ctl_sync_q;
	logic rst_int, strap_sync, byte_sync;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pad_meta_q <= '0;
			pad_sync_q <= '0;
		end else begin
			pad_meta_q <= pad_in;
			pad_sync_q <= pad_meta_q;
		end
	end

	// control pins run free through reset: a cleared strap stage would hide
	// the strap from the mode capture on every reset edge (see R1)
	always_ff @(posedge ref_clk) begin
		ctl_meta_q <= {reset_pin_n, bus_width_pin, processor_mode_strap};
		ctl_sync_q <= ctl_meta_q;
	end

	assign strap_sync = ctl_sync_q[ext_bus_pkg::CS_STRAP];
	assign byte_sync = ctl_sync_q[ext_bus_pkg::CS_BYTE];
	// reset pin low keeps all but the synchronisers in reset (see R2)
	assign rst_int = sys_rst | ~ctl_sync_q[ext_bus_pkg::CS_RST_N];

	// ------------------------------------------------------------
	// processor mode and registers
	// ------------------------------------------------------------
	ext_bus_pkg::proc_mode_e mode_q, mode_d;
	ext_bus_pkg::port_set_t data_q, data_d, dir_q, dir_d;
	logic phase_io_q, phase_io_d;
	logic [7:0] rdata_q, rdata_d;
	logic cfg_wr, ext_mode;

	assign cfg_wr = reg_wr && (reg_addr == ext_bus_pkg::CFG_OFS);
	assign ext_mode = (mode_q != ext_bus_pkg::MODE_SINGLE);

	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			ext_bus_pkg::MODE_SINGLE: begin
				if (cfg_wr && reg_wdata[ext_bus_pkg::CFG_MEMEXP_BIT]) begin
					mode_d = ext_bus_pkg::MODE_MEMEXP;
				end
			end
			ext_bus_pkg::MODE_MEMEXP: begin
				if (cfg_wr && !reg_wdata[ext_bus_pkg::CFG_MEMEXP_BIT]) begin
					mode_d = ext_bus_pkg::MODE_SINGLE;
				end
			end
			ext_bus_pkg::MODE_MICRO: begin
				mode_d = ext_bus_pkg::MODE_MICRO;
			end
			default: begin
				mode_d = ext_bus_pkg::MODE_SINGLE;
			end
		endcase
	end

	always_comb begin
		data_d = data_q;
		dir_d = dir_q;
		phase_io_d = phase_io_q;
		rdata_d = 8'h00;
		if (cfg_wr) begin
			phase_io_d = reg_wdata[ext_bus_pkg::CFG_PHASE_IO_BIT];
		end
		if (reg_rd && reg_addr == ext_bus_pkg::CFG_OFS) begin
			rdata_d[ext_bus_pkg::CFG_MEMEXP_BIT] = (mode_q == ext_bus_pkg::MODE_MEMEXP);
			rdata_d[ext_bus_pkg::CFG_PHASE_IO_BIT] = phase_io_q;
			rdata_d[ext_bus_pkg::CFG_MICRO_BIT] = (mode_q == ext_bus_pkg::MODE_MICRO);
		end
		for (int p = 0; p < ext_bus_pkg::NPORT; p++) begin
			if (reg_wr && reg_addr == ext_bus_pkg::DATA_OFS[p]) begin
				data_d[p] = reg_wdata & ext_bus_pkg::PIN_MASK[p];
			end
			// one direction bit per pin (see R6)
			if (reg_wr && reg_addr == ext_bus_pkg::DIR_OFS[p]) begin
				dir_d[p] = reg_wdata & ext_bus_pkg::PIN_MASK[p];
			end
			// outputs read back the latch, inputs the pin
			if (reg_rd && reg_addr == ext_bus_pkg::DATA_OFS[p]) begin
				rdata_d = ((dir_q[p] & data_q[p]) | (~dir_q[p] & pad_sync_q[p])) & ext_bus_pkg::PIN_MASK[p];
			end
			if (reg_rd && reg_addr == ext_bus_pkg::DIR_OFS[p]) begin
				rdata_d = dir_q[p];
			end
		end
	end

	// the strap is caught on every reset edge, so the last one before release wins
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			mode_q <= strap_sync ? ext_bus_pkg::MODE_MICRO : ext_bus_pkg::MODE_SINGLE; // see R1
			data_q <= '0;
			dir_q <= '0; // see R7
			phase_io_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			mode_q <= mode_d;
			data_q <= data_d;
			dir_q <= dir_d;
			phase_io_q <= phase_io_d;
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// pad multiplexing
	// ------------------------------------------------------------
	ext_bus_pkg::pin_s [ext_bus_pkg::NPORT-1:0] pad_q, pad_d;
	logic [15:0] bus_rdata_q, bus_rdata_d;
	logic hold_q, hold_d, ready_n_q, ready_n_d, en_n_q, en_n_d;
	logic wide, data_phase, drive_data;

	// width pin is sampled live; the partner must not toggle it (see R5)
	assign wide = !byte_sync; // see R4
	assign data_phase = ext_mode && !bus_req.strobe_n;
	assign drive_data = data_phase && bus_req.write;

	always_comb begin
		ext_bus_pkg::port_t sel;
		sel = '0;
		pad_d = pad_q;
		for (int p = 0; p < ext_bus_pkg::NPORT; p++) begin
			// peripheral selection beats the port registers (see R15) (see R16) (see R17) (see R18) (see R19)
			sel = alt_fn[p].sel & ext_bus_pkg::ALT_SEL_MASK[p];
			pad_d[p].out = (sel & alt_fn[p].out) | (~sel & data_q[p]);
			pad_d[p].oe_n = ~(((sel & alt_fn[p].oe & ext_bus_pkg::ALT_OUT_MASK[p]) | (~sel & dir_q[p]))
				& ext_bus_pkg::PIN_MASK[p]);
		end
		if (ext_mode) begin
			pad_d[ext_bus_pkg::P_ZERO].out = bus_req.addr[7:0]; // see R8
			pad_d[ext_bus_pkg::P_ZERO].oe_n = '0;
			if (wide && data_phase) begin
				pad_d[ext_bus_pkg::P_ONE].out = bus_req.wdata[15:8]; // see R9
				pad_d[ext_bus_pkg::P_ONE].oe_n = {ext_bus_pkg::PW{!bus_req.write}};
			end else begin
				pad_d[ext_bus_pkg::P_ONE].out = bus_req.addr[15:8]; // see R10
				pad_d[ext_bus_pkg::P_ONE].oe_n = '0;
			end
			if (data_phase) begin
				pad_d[ext_bus_pkg::P_TWO].out = bus_req.wdata[7:0]; // see R11
				pad_d[ext_bus_pkg::P_TWO].oe_n = {ext_bus_pkg::PW{!bus_req.write}};
			end else begin
				pad_d[ext_bus_pkg::P_TWO].out = bus_req.addr[23:16];
				pad_d[ext_bus_pkg::P_TWO].oe_n = '0;
			end
			pad_d[ext_bus_pkg::P_THREE].out = {4'h0, bus_req.hold_acknowledge, bus_req.ale, bus_req.bhe_n, !bus_req.write}; // see R12
			pad_d[ext_bus_pkg::P_THREE].oe_n = ~ext_bus_pkg::PIN_MASK[ext_bus_pkg::P_THREE];
			pad_d[ext_bus_pkg::P_FOUR].oe_n[ext_bus_pkg::HOLD_BIT] = 1'b1; // see R13
			pad_d[ext_bus_pkg::P_FOUR].oe_n[ext_bus_pkg::READY_BIT] = 1'b1;
			// only expansion mode may hand the phase pin back to the port (see R14)
			if (!(mode_q == ext_bus_pkg::MODE_MEMEXP && phase_io_q)) begin
				pad_d[ext_bus_pkg::P_FOUR].out[ext_bus_pkg::PHASE_BIT] = bus_req.phase;
				pad_d[ext_bus_pkg::P_FOUR].oe_n[ext_bus_pkg::PHASE_BIT] = 1'b0;
			end
		end
	end

	always_comb begin
		bus_rdata_d = bus_rdata_q;
		// read data only sampled inside the strobe (see R3)
		if (data_phase && !bus_req.write) begin
			bus_rdata_d = {wide ? pad_sync_q[ext_bus_pkg::P_ONE] : 8'h00, pad_sync_q[ext_bus_pkg::P_TWO]};
		end
		en_n_d = ext_mode ? bus_req.strobe_n : 1'b1;
		hold_d = ext_mode && !pad_sync_q[ext_bus_pkg::P_FOUR][ext_bus_pkg::HOLD_BIT];
		ready_n_d = ext_mode && pad_sync_q[ext_bus_pkg::P_FOUR][ext_bus_pkg::READY_BIT];
	end

	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			for (int p = 0; p < ext_bus_pkg::NPORT; p++) begin
				pad_q[p].out <= ext_bus_pkg::RESET_VAL;
				pad_q[p].oe_n <= '1; // see R7
			end
			bus_rdata_q <= 16'h0000;
			en_n_q <= 1'b1;
			hold_q <= 1'b0;
			ready_n_q <= 1'b0;
		end else begin
			pad_q <= pad_d;
			bus_rdata_q <= bus_rdata_d;
			en_n_q <= en_n_d;
			hold_q <= hold_d;
			ready_n_q <= ready_n_d;
		end
	end

	logic core_rst_q;

	always_ff @(posedge ref_clk) begin
		core_rst_q <= rst_int; // see R2
	end

	assign pad = pad_q;
	assign pin_level = pad_sync_q;
	assign reg_rdata = rdata_q;
	assign bus_rdata = bus_rdata_q;
	assign hold_request = hold_q;
	assign ready_pin_n = ready_n_q;
	assign enable_strobe_n = en_n_q;
	assign core_reset = core_rst_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_reset_inputs: assert property (@(posedge ref_clk) rst_int |=> (dir_q == '0) && (pad_q[0].oe_n == '1) // see R7
		&& (pad_q[8].oe_n == '1) && core_reset)
		else $error("reset left a pin driven");

	a_strap_mode: assert property (@(posedge ref_clk) $fell(rst_int) |-> // see R1
		(mode_q == ($past(strap_sync) ? ext_bus_pkg::MODE_MICRO : ext_bus_pkg::MODE_SINGLE)))
		else $error("mode does not follow strap");

	a_read_in_strobe: assert property (@(posedge ref_clk) disable iff (rst_int) // see R3
		$changed(bus_rdata_q) |-> $past(data_phase && !bus_req.write))
		else $error("read data taken outside strobe");

	a_port0_address: assert property (@(posedge ref_clk) disable iff (rst_int) // see R8
		ext_mode ##1 !rst_int |-> pad_q[0].oe_n == '0 && pad_q[0].out == $past(bus_req.addr[7:0]))
		else $error("port zero not carrying address");

	a_wide_read: assert property (@(posedge ref_clk) disable iff (rst_int) // see R9
		(data_phase && wide && !bus_req.write) |=> pad_q[1].oe_n == 8'hFF && enable_strobe_n == 1'b0)
		else $error("port one driven during wide read");

	a_narrow_addr: assert property (@(posedge ref_clk) disable iff (rst_int) // see R10
		(ext_mode && !wide) |=> pad_q[1].oe_n == '0 && pad_q[1].out == $past(bus_req.addr[15:8]))
		else $error("port one left address in narrow mode");

	a_port2_phase: assert property (@(posedge ref_clk) disable iff (rst_int) // see R11
		(ext_mode && bus_req.strobe_n) |=> pad_q[2].out == $past(bus_req.addr[23:16]) && enable_strobe_n)
		else $error("port two address phase wrong");

	a_port3_ctrl: assert property (@(posedge ref_clk) disable iff (rst_int) // see R12
		ext_mode |=> pad_q[3].oe_n == 8'hF0 && pad_q[3].out[0] == !$past(bus_req.write))
		else $error("port three control wrong");

	a_hold_input: assert property (@(posedge ref_clk) disable iff (rst_int) // see R13
		ext_mode |=> pad_q[4].oe_n[1:0] == 2'b11)
		else $error("hold or ready pin driven");

	a_phase_micro: assert property (@(posedge ref_clk) disable iff (rst_int) // see R14
		(mode_q == ext_bus_pkg::MODE_MICRO) |=> !pad_q[4].oe_n[2] && pad_q[4].out[2] == $past(bus_req.phase))
		else $error("phase clock freed in microprocessor mode");

	a_dir_output: assert property (@(posedge ref_clk) disable iff (rst_int) // see R6
		(!ext_mode && dir_q[0][0]) |=> !pad_q[0].oe_n[0] && pad_q[0].out[0] == $past(data_q[0][0]))
		else $error("direction bit not honoured");

	a_alt_override: assert property (@(posedge ref_clk) disable iff (rst_int) // see R19
		alt_fn[5].sel[0] |=> pad_q[5].out[0] == $past(alt_fn[5].out[0]) && pad_q[5].oe_n[0] == !$past(alt_fn[5].oe[0]))
		else $error("peripheral does not own pin");

	c_ext_write: cover property (@(posedge ref_clk) disable iff (rst_int) drive_data ##1 !enable_strobe_n);
	c_narrow_read: cover property (@(posedge ref_clk) disable iff (rst_int) data_phase && !wide && !bus_req.write);
	c_phase_gpio: cover property (@(posedge ref_clk) disable iff (rst_int)
		mode_q == ext_bus_pkg::MODE_MEMEXP && phase_io_q);
	c_single_out: cover property (@(posedge ref_clk) disable iff (rst_int) !ext_mode && dir_q[0] != '0);

endmodule

// >>> testbench/ext_mem_model.sv
// far-side bus device model: resolves shared pads and answers external reads
module ext_mem_model (
	input wire ext_bus_pkg::pin_s [8:0] pad,
	input wire logic enable_strobe_n,
	input wire logic [15:0] rd_word,
	input wire ext_bus_pkg::port_set_t far,
	output ext_bus_pkg::port_set_t pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	ext_bus_pkg::port_set_t drv;

	// ------------------------------------------------------------
	// wire resolution
	// ------------------------------------------------------------
	// released lines show the far pattern, never the last driven value
	always_comb begin
		drv = far;
		// answer only in a read data phase, so a wrong lane turn-round collides visibly
		if (!enable_strobe_n && pad[3].out[0] && !pad[3].oe_n[0]) begin
			drv[1] = rd_word[15:8];
			drv[2] = rd_word[7:0];
		end
		for (int i = 0; i < 9; i++)
			pad_in[i] = (pad[i].out & ~pad[i].oe_n) | (drv[i] & pad[i].oe_n);
	end
endmodule

// >>> testbench/tb.sv
// self-checking bench for the pin multiplexer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, sys_rst = 1, rst_n = 1, strap = 0, width = 0, wr = 0, rd = 0, hold, rdy_n, stb_n, crst;
	logic [7:0] ra = 0, wd = 0, rdata;
	logic [15:0] brd, rw = 0;
	ext_bus_pkg::bus_req_s req = '0;
	ext_bus_pkg::alt_s [8:0] alt = '0;
	ext_bus_pkg::port_set_t lvl, pin, far = '0;
	ext_bus_pkg::pin_s [8:0] pad;
	int n_errors = 0, compares = 0, cyc = 0;
	typedef struct {int due; int k; int p; logic [15:0] v;} note_s;
	note_s q[$];

	external_bus_pin_mux uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reset_pin_n(rst_n),
		.processor_mode_strap(strap), .bus_width_pin(width), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdata), .bus_req(req), .bus_rdata(brd), .hold_request(hold),
		.ready_pin_n(rdy_n), .enable_strobe_n(stb_n), .core_reset(crst), .alt_fn(alt), .pin_level(lvl),
		.pad_in(pin), .pad(pad));
	ext_mem_model far_dev (.pad(pad), .enable_strobe_n(stb_n), .rd_word(rw), .far(far), .pad_in(pin));

	initial forever #2 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// notes, compares, monitor
	// ------------------------------------------------------------
	task automatic note(int d, int k, int p, logic [15:0] v);
		q.push_back('{cyc + d, k, p, v});
	endtask

	task automatic cmp_reg(logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: register read %h, expected %h", $time, g, e);
		end
	endtask

	task automatic cmp_pin(int k, int p, logic [15:0] g, e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: kind %0d port %0d got %h, expected %h", $time, k, p, g, e);
		end
	endtask

	// kinds: 0 read data, 1 pad enables, 3 strobe, 4 bus read word, 5 pin levels, 6 hold/ready/reset
	always @(negedge ref_clk) begin
		note_s n;
		cyc++;
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			case (n.k)
				0: cmp_reg(rdata, n.v[7:0]);
				1: cmp_pin(n.k, n.p, {8'h00, pad[n.p].oe_n}, n.v);
				3: cmp_pin(n.k, n.p, {15'h0000, stb_n}, n.v);
				4: cmp_pin(n.k, n.p, brd, n.v);
				5: cmp_pin(n.k, n.p, {8'h00, lvl[n.p]}, n.v);
				default: cmp_pin(n.k, n.p, {13'h0000, hold, rdy_n, crst}, n.v);
			endcase
		end
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task automatic idle(int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wr_reg(logic [7:0] a, d);
		@(posedge ref_clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(logic [7:0] a, e);
		@(posedge ref_clk);
		ra <= a;
		rd <= 1'b1;
		note(2, 0, 0, {8'h00, e});
		@(posedge ref_clk);
		rd <= 1'b0;
	endtask

	task automatic do_reset(logic s, logic w);
		strap <= s;
		width <= w;
		sys_rst <= 1'b1;
		idle(8);
		sys_rst <= 1'b0;
		idle(6);
	endtask

	// one data phase held long enough for the pin synchronisers, then the address phase
	task automatic xfer(logic wrt, logic wide);
		ext_bus_pkg::bus_req_s b;
		logic [15:0] w;
		b = 46'({$urandom, $urandom});
		w = 16'($urandom);
		b.strobe_n = 1'b0;
		b.write = wrt;
		@(posedge ref_clk);
		req <= b;
		rw <= w;
		idle(6);
		note(1, 3, 0, 16'h0000);
		note(1, 1, 4, 16'h00FB);
		note(1, 6, 0, 16'h0006);
		note(1, 5, 0, {8'h00, b.addr[7:0]});
		note(1, 5, 3, {8'h00, far[3][7:4], b.hold_acknowledge, b.ale, b.bhe_n, !wrt});
		note(1, 1, 1, (wide && !wrt) ? 16'h00FF : 16'h0000);
		note(1, 5, 1, {8'h00, wide ? (wrt ? b.wdata[15:8] : w[15:8]) : b.addr[15:8]});
		note(1, 5, 2, {8'h00, wrt ? b.wdata[7:0] : w[7:0]});
		note(1, 1, 2, wrt ? 16'h0000 : 16'h00FF);
		if (!wrt)
			note(1, 4, 0, wide ? w : {8'h00, w[7:0]});
		req.strobe_n <= 1'b1;
		idle(6);
		note(1, 3, 0, 16'h0001);
		note(1, 5, 1, {8'h00, b.addr[15:8]});
		note(1, 5, 2, {8'h00, b.addr[23:16]});
	endtask

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		ext_bus_pkg::port_t d, m;
		void'($urandom(32'h106B));
		for (int i = 0; i < 9; i++)
			far[i] = 8'($urandom);
		far[4][1:0] = 2'b10;
		do_reset(1'b0, 1'b0);
		for (int p = 0; p < 9; p++)
			rd_reg(ext_bus_pkg::DIR_OFS[p], 8'h00);
		rd_reg(8'h00, 8'h00);
		note(1, 1, 0, 16'h00FF);
		rst_n <= 1'b0;
		idle(4);
		note(1, 6, 0, 16'h0001);
		rst_n <= 1'b1;
		idle(4);
		note(1, 6, 0, 16'h0000);
		$display("reset test done");
		req.strobe_n <= 1'b0;
		for (int p = 0; p < 9; p++) begin
			d = 8'($urandom);
			m = 8'($urandom);
			wr_reg(ext_bus_pkg::DATA_OFS[p], d);
			wr_reg(ext_bus_pkg::DIR_OFS[p], m);
			idle(4);
			m &= ext_bus_pkg::PIN_MASK[p];
			note(1, 1, p, {8'h00, ~m});
			note(1, 5, p, {8'h00, (d & m) | (far[p] & ~m)});
			rd_reg(ext_bus_pkg::DIR_OFS[p], m);
			rd_reg(ext_bus_pkg::DATA_OFS[p], ((d & m) | (far[p] & ~m)) & ext_bus_pkg::PIN_MASK[p]);
		end
		note(1, 3, 0, 16'h0001);
		$display("single-chip port test done");
		for (int p = 5; p < 9; p++) begin
			alt[p] <= '{8'hFF, 8'($urandom), 8'($urandom)};
			wr_reg(ext_bus_pkg::DIR_OFS[p], 8'hFF);
		end
		idle(4);
		for (int p = 5; p < 9; p++) begin
			m = alt[p].oe & ext_bus_pkg::ALT_OUT_MASK[p];
			note(1, 1, p, {8'h00, ~m});
			note(1, 5, p, {8'h00, (alt[p].out & m) | (far[p] & ~m)});
		end
		alt <= '0;
		$display("alternate function test done");
		do_reset(1'b1, 1'b0);
		xfer(1'b1, 1'b1);
		xfer(1'b0, 1'b1);
		wr_reg(ext_bus_pkg::CFG_OFS, 8'h02);
		idle(4);
		note(1, 1, 4, 16'h00FB);
		$display("wide microprocessor test done");
		do_reset(1'b1, 1'b1);
		xfer(1'b0, 1'b0);
		xfer(1'b1, 1'b0);
		$display("narrow microprocessor test done");
		do_reset(1'b0, 1'b0);
		rd_reg(ext_bus_pkg::CFG_OFS, 8'h00);
		wr_reg(ext_bus_pkg::CFG_OFS, 8'h01);
		rd_reg(ext_bus_pkg::CFG_OFS, 8'h01);
		xfer(1'b0, 1'b1);
		wr_reg(ext_bus_pkg::CFG_OFS, 8'h03);
		idle(4);
		note(1, 1, 4, 16'h00FF);
		idle(3);
		$display("memory expansion test done");
		summarize();
	end

	// about 290 cycles of tests; cut a hang well beyond that
	initial begin
		#200000;
		n_errors++;
		summarize();
	end
endmodule
